//--- vip_cfg.svh
// Notes on behaviour
// - the unit ranks the pending requests of irqs 0-38 first, then forwards one winner to the core.
// - up to 64 sources, each with one flag bit and one enable bit.
// - sources map onto at most 44 vectors; related requests may share a vector.
// - single-vector mode uses one common vector; multi-vector mode delivers each vector.
// - five external pin inputs, each with its own edge polarity.
// - each vector has a 3-bit priority with seven usable levels.
// - each vector has a 2-bit subpriority that breaks ties at equal priority.
// - the shadow register set is flagged at every priority level in multi-vector mode, or in single mode when control bit 16 is set.
// - a software write to a flag raises the request like a hardware event.
// - the vector table base address is set by software.
// - the spacing between vector entries is set by software.
// - core timer is irq 0 on vector 0, at bit 0 of word 0.
// - irqs 0-31 sit in word 0, irqs 32 and up in word 1.
// - priority word holds four vectors: priority at 4:2, subpriority at 1:0, step 8.
// - capture, converter, usb and serial sources are persistent; others are not.
// - serial1 requests are irqs 36-38, all on vector 31.
// - core software requests are irqs 1 and 2 on vectors 1 and 2.
// - usb is irq 35 on vector 30 and persistent.
// - at equal priority and subpriority the lower irq number wins.
// - control bit 1 selects multi-vector, 0 selects single-vector delivery.
// - 3-bit proximity threshold; requests at or below it start the timer; 0 disables.
// - external pin polarity bit 1 detects rising edges, 0 falling edges.
`ifndef VIP_CFG_SVH
`define VIP_CFG_SVH
`define VIP_ADDR_CTRL 12'h000
`define VIP_ADDR_STAT 12'h010
`define VIP_ADDR_TPTIME 12'h020
`define VIP_ADDR_VBASE 12'h024
`define VIP_ADDR_VSPACE 12'h028
`define VIP_ADDR_FLAG0 12'h030
`define VIP_ADDR_FLAG1 12'h040
`define VIP_ADDR_EN0 12'h060
`define VIP_ADDR_EN1 12'h070
`define VIP_ADDR_PRI0 12'h090
`define VIP_ADDR_PRI_LAST 12'h130
`define VIP_PRI_STRIDE 12'h010
`define VIP_CTRL_SS0_BIT 16
`define VIP_CTRL_MULTI_VECTOR_SELECT_BIT 12
`define VIP_CTRL_TPC_LSB 8
`define VIP_PRI_FIELD_STEP 8
`define VIP_PRI_LSB 2
`define VIP_SUB_LSB 0
`define VIP_NVEC 44
`define VIP_NIRQ 64
`define VIP_NIMPL 39
`define VIP_SPACE_RST 32'h0000_0020
`endif

//--- vip_pkg.sv
package vip_pkg;
  typedef struct packed {
    logic valid;
    logic [5:0] vector;
    logic [5:0] irq;
    logic [2:0] prio;
    logic [1:0] subpriority;
    logic shadow;
    logic [31:0] vec_addr;
  } vip_req_t;
endpackage

//--- vip_prioritizer.sv
`include "vip_cfg.svh"

module vip_prioritizer
  import vip_pkg::*;
#(
  parameter int NIRQ = 64,
  parameter int NVEC = 44
)(
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [NIRQ-1:0] hw_event,
  input wire logic [4:0] ext_pin_irq,
  input wire logic [NIRQ-1:0] persist_hold,
  input wire logic cpu_ack,
  output vip_pkg::vip_req_t cpu_req,
  output logic prox_start
);
  import vip_pkg::*;

  // irq -> vector map; irqs above the implemented range are parked on vector 63 and never win
  function automatic logic [5:0] irq_vec(input int i);
    case (i)
      0, 1, 2, 3, 4, 5: irq_vec = 6'(i);
      6: irq_vec = 6'h05;
      7, 8, 9, 10: irq_vec = 6'(i - 1);
      11: irq_vec = 6'h09;
      12, 13, 14, 15: irq_vec = 6'(i - 2);
      16: irq_vec = 6'h0D;
      17, 18, 19, 20: irq_vec = 6'(i - 3);
      21: irq_vec = 6'h11;
      22, 23, 24, 25: irq_vec = 6'(i - 4);
      26: irq_vec = 6'h15;
      27, 28, 29, 30, 31, 32, 33, 34, 35, 36: irq_vec = 6'(i - 5);
      37, 38: irq_vec = 6'h1F;
      default: irq_vec = 6'h3F;
    endcase
  endfunction

  // persistent: capture, converter, usb, serial1
  function automatic logic irq_persist(input int i);
    irq_persist = (i inside {5, 6, 10, 11, 15, 16, 20, 21, 25, 26, 28, 35, 36, 37, 38});
  endfunction

  function automatic logic [5:0] ext_irq(input int k);
    case (k)
      0: ext_irq = 6'h03;
      1: ext_irq = 6'h08;
      2: ext_irq = 6'h0D;
      3: ext_irq = 6'h12;
      default: ext_irq = 6'h17;
    endcase
  endfunction

  logic [31:0] ctrl_reg, ctrl_next;
  logic [31:0] vbase_reg, vbase_next;
  logic [31:0] vspace_reg, vspace_next;
  logic [31:0] tptime_reg, tptime_next;
  logic [NIRQ-1:0] flag_reg, flag_next;
  logic [NIRQ-1:0] en_reg, en_next;
  logic [31:0] pri_reg [0:10];
  logic [31:0] pri_next [0:10];
  logic [4:0] ext_s1_reg, ext_s2_reg, ext_s3_reg;
  logic [4:0] ext_s1_next, ext_s2_next, ext_s3_next;
  logic [NIRQ-1:0] hw_s1_reg, hw_s2_reg, hw_s1_next, hw_s2_next;
  vip_req_t req_reg, req_next;

  logic wr_acc, rd_acc;
  logic [NIRQ-1:0] ext_evt;
  logic [NIRQ-1:0] pend;
  logic best_v;
  logic [5:0] best_irq, best_vec;
  logic [2:0] best_pri;
  logic [1:0] best_sub;
  logic [31:0] stat_word;

  assign pready = 1'b1;
  assign wr_acc = psel & penable & pwrite;
  assign rd_acc = psel & penable & ~pwrite;

  // pins and event lines cross into mclk through two flops before any edge logic looks at them
  always_comb
  begin
    ext_s1_next = ext_pin_irq;
    ext_s2_next = ext_s1_reg;
    ext_s3_next = ext_s2_reg;
    hw_s1_next = hw_event;
    hw_s2_next = hw_s1_reg;
    ext_evt = '0;
    for (int k = 0; k < 5; k++)
    begin
      // polarity 1 = rising, 0 = falling
      if (ctrl_reg[k])
        ext_evt[ext_irq(k)] = ext_s2_reg[k] & ~ext_s3_reg[k];
      else
        ext_evt[ext_irq(k)] = ~ext_s2_reg[k] & ext_s3_reg[k];
    end
  end

  // register writes; hardware set wins over software clear
  always_comb
  begin
    ctrl_next = ctrl_reg;
    vbase_next = vbase_reg;
    vspace_next = vspace_reg;
    tptime_next = tptime_reg;
    flag_next = flag_reg;
    en_next = en_reg;
    for (int w = 0; w < 11; w++)
      pri_next[w] = pri_reg[w];
    if (wr_acc)
    begin
      if (paddr == `VIP_ADDR_CTRL)
        ctrl_next = pwdata & 32'h0001_171F;
      else if (paddr == `VIP_ADDR_VBASE)
        vbase_next = {pwdata[31:12], 12'h000};
      else if (paddr == `VIP_ADDR_VSPACE)
        vspace_next = {22'h0, pwdata[9:0]};
      else if (paddr == `VIP_ADDR_TPTIME)
        tptime_next = pwdata;
      else if (paddr == `VIP_ADDR_FLAG0)
        flag_next[31:0] = pwdata;
      else if (paddr == `VIP_ADDR_FLAG1)
        flag_next[NIRQ-1:32] = pwdata[NIRQ-33:0];
      else if (paddr == `VIP_ADDR_EN0)
        en_next[31:0] = pwdata;
      else if (paddr == `VIP_ADDR_EN1)
        en_next[NIRQ-1:32] = pwdata[NIRQ-33:0];
      else if (paddr >= `VIP_ADDR_PRI0 && paddr <= `VIP_ADDR_PRI_LAST && paddr[3:0] == 4'h0)
        pri_next[4'((paddr - `VIP_ADDR_PRI0) >> 4)] = pwdata & 32'h1F1F_1F1F;
    end
    // persistent sources re-flag while their peripheral still asserts the condition
    for (int i = 0; i < NIRQ; i++)
      if (hw_s2_reg[i] | ext_evt[i] | (irq_persist(i) & persist_hold[i]))
        flag_next[i] = 1'b1;
  end

  // rank: priority, then subpriority, then lowest irq
  always_comb
  begin
    logic [2:0] p;
    logic [1:0] s;
    logic [5:0] v;
    p = '0;
    s = '0;
    v = '0;
    best_v = 1'b0;
    best_irq = '0;
    best_vec = '0;
    best_pri = '0;
    best_sub = '0;
    pend = flag_reg & en_reg;
    // irqs 39 and up only store flags; they never take part in the ranking
    for (int i = 0; i < `VIP_NIMPL; i++)
    begin
      v = irq_vec(i);
      p = pri_reg[v[5:2]][v[1:0]*`VIP_PRI_FIELD_STEP + `VIP_PRI_LSB +: 3];
      s = pri_reg[v[5:2]][v[1:0]*`VIP_PRI_FIELD_STEP + `VIP_SUB_LSB +: 2];
      // strict compare keeps the earlier (lower) irq on ties
      if (pend[i] && p != 3'h0 && (!best_v || p > best_pri || (p == best_pri && s > best_sub)))
      begin
        best_v = 1'b1;
        best_irq = 6'(i);
        best_vec = v;
        best_pri = p;
        best_sub = s;
      end
    end
  end

  always_comb
  begin
    // the request stands until the core takes it; a flag still pending is offered again after each ack
    req_next = req_reg;
    if (!req_reg.valid || cpu_ack)
    begin
      req_next.valid = best_v;
      req_next.irq = best_irq;
      req_next.prio = best_pri;
      req_next.subpriority = best_sub;
      req_next.shadow = best_v & (ctrl_reg[`VIP_CTRL_MULTI_VECTOR_SELECT_BIT] | ctrl_reg[`VIP_CTRL_SS0_BIT]);
      if (ctrl_reg[`VIP_CTRL_MULTI_VECTOR_SELECT_BIT])
      begin
        req_next.vector = best_vec;
        req_next.vec_addr = vbase_reg + 32'(best_vec) * vspace_reg;
      end
      else
      begin
        req_next.vector = 6'h00;
        req_next.vec_addr = vbase_reg;
      end
    end
  end

  assign prox_start = req_reg.valid && ctrl_reg[`VIP_CTRL_TPC_LSB +: 3] != 3'h0
    && req_reg.prio <= ctrl_reg[`VIP_CTRL_TPC_LSB +: 3];

  always_comb
  begin
    stat_word = {21'h0, req_reg.prio, 2'h0, req_reg.vector};
    prdata = 32'h0000_0000;
    pslverr = 1'b0;
    if (rd_acc || wr_acc)
    begin
      if (paddr == `VIP_ADDR_CTRL)
        prdata = ctrl_reg;
      else if (paddr == `VIP_ADDR_STAT)
        prdata = stat_word;
      else if (paddr == `VIP_ADDR_TPTIME)
        prdata = tptime_reg;
      else if (paddr == `VIP_ADDR_VBASE)
        prdata = vbase_reg;
      else if (paddr == `VIP_ADDR_VSPACE)
        prdata = vspace_reg;
      else if (paddr == `VIP_ADDR_FLAG0)
        prdata = flag_reg[31:0];
      else if (paddr == `VIP_ADDR_FLAG1)
        prdata = flag_reg[NIRQ-1:32];
      else if (paddr == `VIP_ADDR_EN0)
        prdata = en_reg[31:0];
      else if (paddr == `VIP_ADDR_EN1)
        prdata = en_reg[NIRQ-1:32];
      else if (paddr >= `VIP_ADDR_PRI0 && paddr <= `VIP_ADDR_PRI_LAST && paddr[3:0] == 4'h0)
        prdata = pri_reg[4'((paddr - `VIP_ADDR_PRI0) >> 4)];
      else
        pslverr = 1'b1;
    end
  end

  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      ctrl_reg <= '0;
      vbase_reg <= '0;
      vspace_reg <= `VIP_SPACE_RST;
      tptime_reg <= '0;
      flag_reg <= '0;
      en_reg <= '0;
      for (int w = 0; w < 11; w++)
        pri_reg[w] <= '0;
      ext_s1_reg <= '0;
      ext_s2_reg <= '0;
      ext_s3_reg <= '0;
      hw_s1_reg <= '0;
      hw_s2_reg <= '0;
      req_reg <= '0;
    end
    else
    begin
      ctrl_reg <= ctrl_next;
      vbase_reg <= vbase_next;
      vspace_reg <= vspace_next;
      tptime_reg <= tptime_next;
      flag_reg <= flag_next;
      en_reg <= en_next;
      for (int w = 0; w < 11; w++)
        pri_reg[w] <= pri_next[w];
      ext_s1_reg <= ext_s1_next;
      ext_s2_reg <= ext_s2_next;
      ext_s3_reg <= ext_s3_next;
      hw_s1_reg <= hw_s1_next;
      hw_s2_reg <= hw_s2_next;
      req_reg <= req_next;
    end
  end

  assign cpu_req = req_reg;

  property p_flag_sticky;
    @(posedge mclk) disable iff (sys_rst)
    (flag_reg[0] && !(wr_acc && paddr == `VIP_ADDR_FLAG0)) |=> flag_reg[0];
  endproperty
  a_flag_sticky: assert property (p_flag_sticky) else $error("flag dropped without a clear");

  property p_hw_sets;
    @(posedge mclk) disable iff (sys_rst)
    hw_event[0] |-> ##3 flag_reg[0];
  endproperty
  a_hw_sets: assert property (p_hw_sets) else $error("event did not set flag in three cycles");

  property p_sw_sets;
    @(posedge mclk) disable iff (sys_rst)
    (wr_acc && paddr == `VIP_ADDR_FLAG0) |=> (flag_reg[31:0] & $past(pwdata)) == $past(pwdata);
  endproperty
  a_sw_sets: assert property (p_sw_sets) else $error("software flag set lost");

  property p_no_pri0;
    @(posedge mclk) disable iff (sys_rst)
    req_reg.valid |-> req_reg.prio != 3'h0;
  endproperty
  a_no_pri0: assert property (p_no_pri0) else $error("priority zero forwarded");

  property p_single_vec;
    @(posedge mclk) disable iff (sys_rst)
    (req_reg.valid && (!$past(req_reg.valid) || $past(cpu_ack)) && !ctrl_reg[`VIP_CTRL_MULTI_VECTOR_SELECT_BIT] && $stable(ctrl_reg))
      |-> req_reg.vector == 6'h00;
  endproperty
  a_single_vec: assert property (p_single_vec) else $error("single mode gave non-zero vector");

  property p_pend_forward;
    @(posedge mclk) disable iff (sys_rst)
    (best_v && !req_reg.valid) |=> req_reg.valid && req_reg.irq == $past(best_irq);
  endproperty
  a_pend_forward: assert property (p_pend_forward) else $error("winner not forwarded next cycle");

  property p_prox_off;
    @(posedge mclk) disable iff (sys_rst)
    (ctrl_reg[`VIP_CTRL_TPC_LSB +: 3] == 3'h0) |-> !prox_start;
  endproperty
  a_prox_off: assert property (p_prox_off) else $error("proximity timer started while disabled");

  property p_addr_calc;
    @(posedge mclk) disable iff (sys_rst)
    (req_reg.valid && (!$past(req_reg.valid) || $past(cpu_ack)) && ctrl_reg[`VIP_CTRL_MULTI_VECTOR_SELECT_BIT]
      && $stable(vbase_reg) && $stable(vspace_reg) && $stable(ctrl_reg))
      |-> req_reg.vec_addr == vbase_reg + 32'(req_reg.vector) * vspace_reg;
  endproperty
  a_addr_calc: assert property (p_addr_calc) else $error("vector address wrong");

  property p_shadow;
    @(posedge mclk) disable iff (sys_rst)
    (req_reg.valid && (!$past(req_reg.valid) || $past(cpu_ack)) && ctrl_reg[`VIP_CTRL_MULTI_VECTOR_SELECT_BIT] && $stable(ctrl_reg))
      |-> req_reg.shadow;
  endproperty
  a_shadow: assert property (p_shadow) else $error("shadow set not flagged");

  // a request the core has not taken must not change under it
  property p_req_hold;
    @(posedge mclk) disable iff (sys_rst)
    (req_reg.valid && !cpu_ack) |=> $stable(req_reg);
  endproperty
  a_req_hold: assert property (p_req_hold) else $error("request changed before the core took it");

  property p_impl_only;
    @(posedge mclk) disable iff (sys_rst)
    req_reg.valid |-> req_reg.irq < 6'(`VIP_NIMPL);
  endproperty
  a_impl_only: assert property (p_impl_only) else $error("unranked source forwarded");

  property p_vec_map;
    @(posedge mclk) disable iff (sys_rst)
    (req_reg.valid && (!$past(req_reg.valid) || $past(cpu_ack))
      && ctrl_reg[`VIP_CTRL_MULTI_VECTOR_SELECT_BIT] && $stable(ctrl_reg))
      |-> req_reg.vector == irq_vec(int'(req_reg.irq));
  endproperty
  a_vec_map: assert property (p_vec_map) else $error("vector does not match source");

  property p_ext_rise;
    @(posedge mclk) disable iff (sys_rst)
    (ctrl_reg[0] && ext_s2_reg[0] && !ext_s3_reg[0]) |=> flag_reg[ext_irq(0)];
  endproperty
  a_ext_rise: assert property (p_ext_rise) else $error("rising pin edge not flagged");

  property p_ext_fall;
    @(posedge mclk) disable iff (sys_rst)
    (!ctrl_reg[1] && !ext_s2_reg[1] && ext_s3_reg[1]) |=> flag_reg[ext_irq(1)];
  endproperty
  a_ext_fall: assert property (p_ext_fall) else $error("falling pin edge not flagged");

  c_multi: cover property (@(posedge mclk) disable iff (sys_rst) req_reg.valid && ctrl_reg[`VIP_CTRL_MULTI_VECTOR_SELECT_BIT]);
  c_single: cover property (@(posedge mclk) disable iff (sys_rst) req_reg.valid && !ctrl_reg[`VIP_CTRL_MULTI_VECTOR_SELECT_BIT]);
  c_ack: cover property (@(posedge mclk) disable iff (sys_rst) req_reg.valid && cpu_ack);
  c_prox: cover property (@(posedge mclk) disable iff (sys_rst) prox_start);
  c_sub: cover property (@(posedge mclk) disable iff (sys_rst) req_reg.valid && req_reg.subpriority != 2'h0);
endmodule // vip_prioritizer

//--- vip_core_model.sv
module vip_core_model
  import vip_pkg::*;
(
  input wire logic mclk,
  input wire logic sys_rst,
  input wire vip_pkg::vip_req_t cpu_req,
  input wire logic [3:0] dly,
  output logic cpu_ack,
  output vip_pkg::vip_req_t got,
  output logic [15:0] takes
);
  timeunit 1ns;
  timeprecision 1ns;
  import vip_pkg::*;
  logic [3:0] wait_reg;
  // a slow core lets the request stand for dly cycles before taking it
  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      cpu_ack <= 1'h0;
      wait_reg <= 4'h0;
      takes <= 16'h0;
      got <= '0;
    end
    else
    begin
      cpu_ack <= 1'h0;
      // no second ack before the unit has reloaded its request
      if (cpu_req.valid && !cpu_ack)
      begin
        if (wait_reg >= dly)
        begin
          cpu_ack <= 1'h1;
          got <= cpu_req;
          takes <= takes + 16'h1;
          wait_reg <= 4'h0;
        end
        else
          wait_reg <= wait_reg + 4'h1;
      end
    end
  end
endmodule // vip_core_model

//--- vip_prioritizer_tb.sv
`include "vip_cfg.svh"
module vip_prioritizer_tb;
  timeunit 1ns;
  timeprecision 1ns;
  import vip_pkg::*;
  typedef struct packed {logic [5:0] irq; logic [5:0] vec; logic [2:0] pri; logic [31:0] ctrl; logic [2:0] pin;} vip_row_t;
  logic mclk = 1'h0, sys_rst = 1'h1, psel = 1'h0, penable = 1'h0, pwrite = 1'h0, pready, pslverr, cpu_ack, prox_start;
  logic perr;
  logic [11:0] paddr = 12'h0;
  logic [31:0] pwdata = 32'h0, prdata, rdv;
  logic [31:0] pw [0:10] = '{default: 32'h0};
  logic [63:0] hw_event = 64'h0, persist_hold = 64'h0;
  logic [4:0] ext_pin_irq = 5'h1E;
  logic [3:0] dly = 4'h0;
  logic [15:0] takes, snap;
  vip_req_t cpu_req, got;
  vip_row_t r;
  int errors = 0, comparisons = 0, cycles = 0;
  // ctrl: 0x1000 multi vector, 0x10000 shadow in single mode, 10:8 threshold, 4:0 pin polarity
  vip_row_t rows [11] = '{
    '{6'h00, 6'h00, 3'h3, 32'h00001300, 3'h7},
    '{6'h01, 6'h01, 3'h4, 32'h00001300, 3'h7},
    '{6'h02, 6'h02, 3'h7, 32'h00000000, 3'h7},
    '{6'h06, 6'h05, 3'h1, 32'h00010700, 3'h7},
    '{6'h1C, 6'h17, 3'h2, 32'h00001000, 3'h7},
    '{6'h20, 6'h1B, 3'h5, 32'h00001000, 3'h7},
    '{6'h23, 6'h1E, 3'h6, 32'h00001000, 3'h7},
    '{6'h25, 6'h1F, 3'h1, 32'h00001100, 3'h7},
    '{6'h26, 6'h1F, 3'h7, 32'h00001000, 3'h7},
    '{6'h03, 6'h03, 3'h2, 32'h00001001, 3'h0},
    '{6'h08, 6'h07, 3'h2, 32'h00001000, 3'h1}};
  logic [31:0] pm [4] = '{32'h270, 32'h260, 32'h060, 32'h040};
  logic [5:0] pe [4] = '{6'h04, 6'h09, 6'h05, 6'h06};

  vip_prioritizer vip_prioritizer_inst (.mclk(mclk), .sys_rst(sys_rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .hw_event(hw_event), .ext_pin_irq(ext_pin_irq), .persist_hold(persist_hold), .cpu_ack(cpu_ack),
    .cpu_req(cpu_req), .prox_start(prox_start));
  vip_core_model vip_core_model_inst (.mclk(mclk), .sys_rst(sys_rst), .cpu_req(cpu_req), .dly(dly),
    .cpu_ack(cpu_ack), .got(got), .takes(takes));

  always #5 mclk = ~mclk;

  task results;
    $display("errors %0d comparisons %0d", errors, comparisons);
    if (errors == 0 && comparisons > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  task chk(input string n, input logic [31:0] s, input logic [31:0] e);
    comparisons++;
    if (s !== e)
    begin
      errors++;
      $display("wrong value %s expected %h seen %h", n, e, s);
    end
  endtask

  // entered just after a rising edge; leaves one idle cycle so psel is never driven twice in a step
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'h1;
    repeat (20)
    begin
      @(posedge mclk);
      if (pready === 1'h1)
        break;
    end
    rdv = prdata;
    perr = pslverr;
    chk("pready", 32'(pready), 32'h1);
    psel <= 1'h0;
    penable <= 1'h0;
    @(posedge mclk);
  endtask

  task wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'h1, a, d);
  endtask

  task rd(input logic [11:0] a, input logic [31:0] e);
    apb(1'h0, a, 32'h0);
    chk("rdata", rdv, e);
  endtask

  task setpri(input logic [5:0] v, input logic [2:0] p, input logic [1:0] s);
    pw[v[5:2]][v[1:0] * 8 +: 5] = {p, s};
    wr(`VIP_ADDR_PRI0 + `VIP_PRI_STRIDE * v[5:2], pw[v[5:2]]);
  endtask

  task take(input logic [15:0] n);
    repeat (80)
    begin
      @(posedge mclk);
      if (takes == n)
        break;
    end
    chk("take", 32'(takes), 32'(n));
  endtask

  task drain;
    repeat (80)
    begin
      @(posedge mclk);
      if (cpu_req.valid === 1'h0)
        break;
    end
    chk("idle", 32'(cpu_req.valid), 32'h0);
  endtask

  always @(posedge mclk)
  begin
    cycles <= cycles + 1;
    if (cycles == 8000)
    begin
      errors++;
      results();
    end
  end

  initial
  begin
    repeat (20) @(posedge mclk);
    sys_rst <= 1'h0;
    @(posedge mclk);
    chk("reset req", 32'(cpu_req[50:32]), 32'h0);
    chk("reset addr", cpu_req.vec_addr, 32'h0);
    chk("reset prox", 32'(prox_start), 32'h0);
    rd(`VIP_ADDR_CTRL, 32'h0);
    rd(`VIP_ADDR_VSPACE, `VIP_SPACE_RST);
    apb(1'h0, 12'h050, 32'h0);
    chk("unmapped", {perr, rdv[30:0]}, 32'h80000000);
    wr(`VIP_ADDR_VBASE, 32'h1000);
    wr(`VIP_ADDR_VSPACE, 32'h40);
    rd(`VIP_ADDR_VBASE, 32'h1000);
    wr(`VIP_ADDR_TPTIME, 32'hA5A5_5A5A);
    rd(`VIP_ADDR_TPTIME, 32'hA5A5_5A5A);
    foreach (rows[i])
    begin
      r = rows[i];
      dly <= i[0] ? 4'h5 : 4'h0;
      wr(`VIP_ADDR_CTRL, r.ctrl);
      setpri(r.vec, r.pri, 2'h0);
      wr(r.irq[5] ? `VIP_ADDR_EN1 : `VIP_ADDR_EN0, 32'h1 << r.irq[4:0]);
      snap = takes;
      if (r.pin == 3'h7)
        hw_event[r.irq] <= 1'h1;
      else
        ext_pin_irq[r.pin] <= ~ext_pin_irq[r.pin];
      @(posedge mclk);
      hw_event <= 64'h0;
      take(snap + 16'h1);
      chk("vector", 32'(got.vector), r.ctrl[12] ? 32'(r.vec) : 32'h0);
      chk("irq", 32'(got.irq), 32'(r.irq));
      chk("priority", 32'(got.prio), 32'(r.pri));
      chk("addr", got.vec_addr, 32'h1000 + (r.ctrl[12] ? 32'(r.vec) * 32'h40 : 32'h0));
      chk("shadow", 32'(got.shadow), 32'(r.ctrl[12] | r.ctrl[16]));
      chk("prox", 32'(prox_start), 32'(r.pri <= r.ctrl[10:8] && r.ctrl[10:8] != 3'h0));
      rd(`VIP_ADDR_STAT, {21'h0, r.pri, 2'h0, r.ctrl[12] ? r.vec : 6'h00});
      rd(r.irq[5] ? `VIP_ADDR_FLAG1 : `VIP_ADDR_FLAG0, 32'h1 << r.irq[4:0]);
      wr(`VIP_ADDR_EN0, 32'h0);
      wr(`VIP_ADDR_EN1, 32'h0);
      wr(`VIP_ADDR_FLAG0, 32'h0);
      wr(`VIP_ADDR_FLAG1, 32'h0);
      drain();
    end
    // ranking: vector 4 by priority, then vector 8 by subpriority, then irq 5 before 6 on one vector
    wr(`VIP_ADDR_CTRL, 32'h1000);
    setpri(6'h04, 3'h6, 2'h0);
    setpri(6'h05, 3'h5, 2'h2);
    setpri(6'h08, 3'h5, 2'h3);
    wr(`VIP_ADDR_EN0, 32'h270);
    for (int k = 0; k < 4; k++)
    begin
      wr(`VIP_ADDR_FLAG0, pm[k]);
      snap = takes;
      take(snap + 16'h2);
      chk("winner", 32'(got.irq), 32'(pe[k]));
    end
    setpri(6'h05, 3'h0, 2'h0);
    drain();
    wr(`VIP_ADDR_EN0, 32'h0);
    // flags latch with enables off; a persistent source re-sets its flag while held
    hw_event[10] <= 1'h1;
    persist_hold <= 64'h10000010;
    @(posedge mclk);
    hw_event <= 64'h0;
    wr(`VIP_ADDR_FLAG0, 32'h0);
    repeat (5) @(posedge mclk);
    rd(`VIP_ADDR_FLAG0, 32'h10000400);
    persist_hold <= 64'h0;
    @(posedge mclk);
    wr(`VIP_ADDR_FLAG0, 32'h0);
    rd(`VIP_ADDR_FLAG0, 32'h0);
    // a request left standing when reset arrives must vanish with the rest of the state
    wr(`VIP_ADDR_EN0, 32'h1);
    wr(`VIP_ADDR_FLAG0, 32'h1);
    repeat (3) @(posedge mclk);
    chk("pending", 32'(cpu_req.valid), 32'h1);
    sys_rst <= 1'h1;
    repeat (2) @(posedge mclk);
    sys_rst <= 1'h0;
    @(posedge mclk);
    chk("mid reset req", 32'(cpu_req[50:32]), 32'h0);
    chk("mid reset addr", cpu_req.vec_addr, 32'h0);
    rd(`VIP_ADDR_FLAG0, 32'h0);
    rd(`VIP_ADDR_EN0, 32'h0);
    rd(`VIP_ADDR_CTRL, 32'h0);
    rd(`VIP_ADDR_VSPACE, `VIP_SPACE_RST);
    results();
  end
endmodule // vip_prioritizer_tb
